// file: include/acsc_pkg.sv
/*
 Constants, carriers and state type of the converter sequencing control.
 Assumes a host bus front end that decodes the card base and hands over
 one-cycle read and write strobes with a 4-bit port offset.
*/
package acsc_pkg;
	// Port offsets
	localparam logic [3:0] OFS_DAC_DATA  = 4'h0;
	localparam logic [3:0] OFS_DAC_CTRL  = 4'h1;
	localparam logic [3:0] OFS_DAC_DMA   = 4'h2;
	localparam logic [3:0] OFS_ADC_DATA  = 4'h3;
	localparam logic [3:0] OFS_ADC_CTRL  = 4'h4;
	localparam logic [3:0] OFS_ADC_START = 4'h5;
	localparam logic [3:0] OFS_MUX_STAT  = 4'h6;
	// ADC control fields
	localparam int ADC_GAIN_LSB = 0;
	localparam int ADC_DIFF_BIT = 2;
	localparam int ADC_TMR_BIT  = 3;
	localparam int ADC_DMA_BIT  = 4;
	localparam int ADC_AUTO_BIT = 5;
	localparam int ADC_MODE_LSB = 6;
	localparam logic [1:0] MODE_IO      = 2'h0;
	localparam logic [1:0] MODE_AUTO    = 2'h1;
	localparam logic [1:0] MODE_ILLEGAL = 2'h2;
	localparam logic [1:0] MODE_TIMER   = 2'h3;
	// DAC control fields
	localparam int DAC_CHAN_LSB = 0;
	localparam int DAC_REF_BIT  = 2;
	localparam int DAC_TMR_BIT  = 3;
	localparam int DAC_DMA_BIT  = 4;
	localparam int DAC_AUTO_BIT = 5;
	localparam int DAC_CONT_BIT = 6;
	localparam int DAC_TUPD_BIT = 7;
	// Mux and mask write fields
	localparam int MASK_LSB     = 0;
	localparam int ADC_CHAN_LSB = 4;
	// Values after reset or card clear
	localparam logic [7:0]  CTRL_RST = 8'h00;
	localparam logic [3:0]  MASK_RST = 4'h0;
	localparam logic [3:0]  CHAN_RST = 4'h0;
	localparam logic [11:0] DATA_RST = 12'h000;
	localparam logic [7:0]  RD_NONE  = 8'h00;
	// Host settle time after a mode change, kept by software
	localparam int MODE_SETTLE_US  = 10;
	localparam int CLK_MHZ         = 100;
	localparam int MODE_SETTLE_CYC = MODE_SETTLE_US * CLK_MHZ;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [3:0] addr;
		logic [7:0] wdata;
	} acsc_io_req_s;

	typedef struct packed {
		logic [1:0] gain;
		logic       diff;
		logic [3:0] chan;
	} acsc_adc_cfg_s;

	typedef enum logic [1:0] {
		S_IDLE,
		S_CONV,
		S_DONE
	} acsc_adc_st_e;
endpackage

// file: rtl/acsc_pair.sv
/*
 Byte pointer for two-access transfers: low byte first, then high.
 Assumes clear and step come from logic on the same clock.
*/
`timescale 1ns/10ps
module acsc_pair (
	input  wire logic clk_i,
	input  wire logic clr_i,
	input  wire logic step_i,
	output logic      hi_o
);
	logic hi_ff;

	always_ff @(posedge clk_i)
	begin
		if (clr_i)
			hi_ff <= 1'b0;
		else if (step_i)
			hi_ff <= ~hi_ff;
	end

	assign hi_o = hi_ff;
endmodule

// file: rtl/acsc_sync.sv
/*
 Two-stage synchroniser with a rising-edge pulse taken after stage two.
 Assumes asynchronous pin inputs and one system clock.
*/
`timescale 1ns/10ps
module acsc_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_i,
	input  wire logic         rst_i,
	input  wire logic [W-1:0] d_i,
	output logic      [W-1:0] q_o,
	output logic      [W-1:0] rise_o
);
	logic [W-1:0] s1_ff;
	logic [W-1:0] s2_ff;
	logic [W-1:0] s3_ff;

	// Stage one feeds stage two only
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1_ff <= '0;
			s2_ff <= '0;
			s3_ff <= '0;
		end
		else
		begin
			s1_ff <= d_i;
			s2_ff <= s1_ff;
			s3_ff <= s2_ff;
		end
	end

	assign q_o    = s2_ff;
	assign rise_o = s2_ff & ~s3_ff;
endmodule

// file: rtl/acsc_top.sv
/*
 Converter sequencing control: host port decode, ADC trigger sequencing,
 DAC data pairing, channel masking and DMA requests.
 Assumes host strobes and DMA terminal count are on clk_i; converter
 end-of-conversion, timer ticks and gate pins are asynchronous.
*/
`timescale 1ns/10ps
// Operation
// - Mode bits 7:6 pick ADC trigger
// - ADC control read resets sequencer only
// - Mode 00: start write runs one conversion
// - Busy status high during conversion
// - ADC data reads alternate low, high
// - Mux write upper nibble sets channel
// - Mode 01: reads retrigger after first start
// - Mode 11: timer tick starts conversion
// - Bit4 DMA, bit3 timer enable
// - Timer DMA: request and interrupt each result
// - Gate inhibits timer; ADC gate status bit1
// - DAC data: low byte, then high nibble
// - DAC control read resets DAC sequencer
// - Offset two write starts DAC DMA
// - Mask bits 3:0 gate DAC channels
// - Interrupt on each DAC channel update
// - DAC control bits 1:0 channel
// - DAC bit2 reference; clear forces zero
// - DAC bits 3,4,7: timer, DMA, tick update
// - DAC bit5 auto increment, bit6 continue
// - Offset zero read clears whole card
// - ADC bits 1:0 select gain
// - ADC bit2 selects differential inputs
// - Auto mode restarts after both bytes
// - Mask zero updates, one blocks
module acsc_top (
	input  wire logic                   clk_i,
	input  wire logic                   rst_i,
	input  wire acsc_pkg::acsc_io_req_s io_i,
	output logic [7:0]                  io_rdata_o,
	input  wire logic                   dma_tc_i,
	input  wire logic                   adc_eoc_i,
	input  wire logic [11:0]            adc_result_i,
	input  wire logic                   adc_tick_i,
	input  wire logic                   adc_gate_i,
	input  wire logic                   dac_tick_i,
	input  wire logic                   dac_gate_i,
	output acsc_pkg::acsc_adc_cfg_s     adc_cfg_o,
	output logic                        adc_start_o,
	output logic                        adc_tmr_en_o,
	output logic                        adc_dma_req_o,
	output logic                        adc_irq_o,
	output logic [11:0]                 dac_data_o,
	output logic [3:0]                  dac_wr_o,
	output logic [1:0]                  dac_chan_o,
	output logic                        dac_ref_en_o,
	output logic                        dac_tmr_en_o,
	output logic                        dac_dma_req_o,
	output logic                        dac_irq_o
);
	logic [7:0]           adc_ctrl_ff;
	logic [7:0]           dac_ctrl_ff;
	logic [3:0]           mask_ff;
	logic [3:0]           adc_chan_ff;
	logic [11:0]          adc_res_ff;
	logic [7:0]           dac_lo_ff;
	logic [1:0]           dac_chan_ff;
	logic                 dac_act_ff;
	logic                 adc_start_ff;
	logic                 adc_dma_ff;
	logic                 adc_irq_ff;
	logic                 dac_req_ff;
	logic                 dac_irq_ff;
	logic [3:0]           dac_wr_ff;
	logic [11:0]          dac_data_ff;
	logic [7:0]           rdata_ff;
	acsc_pkg::acsc_adc_st_e st_ff;
	acsc_pkg::acsc_adc_st_e nxt_st;
	logic [4:0]           pin_q;
	logic [4:0]           pin_rise;
	logic [11:0]          res_q;
	logic                 card_clr;
	logic                 adc_clr;
	logic                 dac_clr;
	logic                 rd_adc;
	logic                 wr0;
	logic                 adc_hi;
	logic                 dac_hi;
	logic                 data_read;
	logic                 word_ev;
	logic                 upd_ev;
	logic                 start_go;
	logic                 eoc_done;
	logic [1:0]           mode;
	logic [3:0]           chan_mask;

	function automatic logic hit(input logic s, input logic [3:0] a,
		input logic [3:0] o);
		hit = s && (a == o);
	endfunction

	// Pins: 0 eoc, 1 adc tick, 2 adc gate, 3 dac tick, 4 dac gate
	acsc_sync #(.W(5)) u_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.d_i    ({dac_gate_i, dac_tick_i, adc_gate_i, adc_tick_i,
			adc_eoc_i}),
		.q_o    (pin_q),
		.rise_o (pin_rise)
	);

	// The result bus settles well before eoc, so a two-flop pass is safe
	acsc_sync #(.W(12)) u_res_sync (
		.clk_i  (clk_i),
		.rst_i  (rst_i),
		.d_i    (adc_result_i),
		.q_o    (res_q),
		.rise_o ()
	);

	assign card_clr = rst_i | hit(io_i.rd, io_i.addr, acsc_pkg::OFS_DAC_DATA);
	assign adc_clr  = card_clr | hit(io_i.rd, io_i.addr, acsc_pkg::OFS_ADC_CTRL);
	assign dac_clr  = card_clr | hit(io_i.rd, io_i.addr, acsc_pkg::OFS_DAC_CTRL);
	assign rd_adc   = hit(io_i.rd, io_i.addr, acsc_pkg::OFS_ADC_DATA);
	assign wr0      = hit(io_i.wr, io_i.addr, acsc_pkg::OFS_DAC_DATA);
	assign mode     = adc_ctrl_ff[acsc_pkg::ADC_MODE_LSB +: 2];

	acsc_pair u_adc_pair (
		.clk_i  (clk_i),
		.clr_i  (adc_clr),
		.step_i (rd_adc),
		.hi_o   (adc_hi)
	);

	acsc_pair u_dac_pair (
		.clk_i  (clk_i),
		.clr_i  (dac_clr),
		.step_i (wr0),
		.hi_o   (dac_hi)
	);

	// Control registers; a read of a control port never touches them
	always_ff @(posedge clk_i)
	begin
		if (card_clr)
		begin
			adc_ctrl_ff <= acsc_pkg::CTRL_RST;
			dac_ctrl_ff <= acsc_pkg::CTRL_RST;
			mask_ff     <= acsc_pkg::MASK_RST;
		end
		else if (io_i.wr)
		begin
			if (io_i.addr == acsc_pkg::OFS_ADC_CTRL)
				adc_ctrl_ff <= io_i.wdata;
			if (io_i.addr == acsc_pkg::OFS_DAC_CTRL)
				dac_ctrl_ff <= io_i.wdata;
			if (io_i.addr == acsc_pkg::OFS_MUX_STAT)
				mask_ff <= io_i.wdata[acsc_pkg::MASK_LSB +: 4];
		end
	end

	// ADC conversion sequencer
	assign data_read = rd_adc & adc_hi;
	assign eoc_done  = (st_ff == acsc_pkg::S_CONV) & pin_q[0] & pin_rise[0];

	always_comb
	begin
		start_go = 1'b0;
		case (mode)
			acsc_pkg::MODE_IO:
				start_go = hit(io_i.wr, io_i.addr, acsc_pkg::OFS_ADC_START);
			acsc_pkg::MODE_AUTO:
				start_go = hit(io_i.wr, io_i.addr, acsc_pkg::OFS_ADC_START)
					| ((st_ff == acsc_pkg::S_DONE) & data_read);
			acsc_pkg::MODE_TIMER:
				// Gate low holds the timer off, so its ticks are ignored
				start_go = adc_ctrl_ff[acsc_pkg::ADC_TMR_BIT] & pin_q[2]
					& pin_rise[1];
			default:
				start_go = 1'b0;
		endcase
		// A start while converting is dropped; the converter cannot queue
		if (st_ff == acsc_pkg::S_CONV)
			start_go = 1'b0;
	end

	always_comb
	begin
		nxt_st = st_ff;
		case (st_ff)
			acsc_pkg::S_IDLE:
				if (start_go)
					nxt_st = acsc_pkg::S_CONV;
			acsc_pkg::S_CONV:
				if (eoc_done)
					nxt_st = acsc_pkg::S_DONE;
			acsc_pkg::S_DONE:
				if (start_go)
					nxt_st = acsc_pkg::S_CONV;
			default:
				nxt_st = acsc_pkg::S_IDLE;
		endcase
	end

	always_ff @(posedge clk_i)
	begin
		if (adc_clr)
			st_ff <= acsc_pkg::S_IDLE;
		else
			st_ff <= nxt_st;
	end

	always_ff @(posedge clk_i)
	begin
		if (adc_clr)
			adc_start_ff <= 1'b0;
		else
			adc_start_ff <= start_go;
	end

	always_ff @(posedge clk_i)
	begin
		if (card_clr)
			adc_res_ff <= acsc_pkg::DATA_RST;
		else if (eoc_done)
			adc_res_ff <= res_q;
	end

	// Channel wraps at 8 in differential mode
	assign chan_mask = adc_ctrl_ff[acsc_pkg::ADC_DIFF_BIT] ? 4'h7 : 4'hF;

	always_ff @(posedge clk_i)
	begin
		if (card_clr)
			adc_chan_ff <= acsc_pkg::CHAN_RST;
		else if (hit(io_i.wr, io_i.addr, acsc_pkg::OFS_MUX_STAT))
			adc_chan_ff <= io_i.wdata[acsc_pkg::ADC_CHAN_LSB +: 4];
		else if (eoc_done & adc_ctrl_ff[acsc_pkg::ADC_AUTO_BIT])
			adc_chan_ff <= (adc_chan_ff + 4'h1) & chan_mask;
	end

	// DMA request stands until both bytes are read; a new result wins
	always_ff @(posedge clk_i)
	begin
		if (adc_clr)
			adc_dma_ff <= 1'b0;
		else if (eoc_done & adc_ctrl_ff[acsc_pkg::ADC_DMA_BIT])
			adc_dma_ff <= 1'b1;
		else if (data_read)
			adc_dma_ff <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (adc_clr)
			adc_irq_ff <= 1'b0;
		else
			adc_irq_ff <= eoc_done;
	end

	// DAC data pairing and update
	assign word_ev = wr0 & dac_hi;
	assign upd_ev  = dac_ctrl_ff[acsc_pkg::DAC_TUPD_BIT]
		? (dac_ctrl_ff[acsc_pkg::DAC_TMR_BIT] & pin_q[4]
			& pin_rise[3])
		: word_ev;

	always_ff @(posedge clk_i)
	begin
		if (card_clr)
			dac_lo_ff <= 8'h00;
		else if (wr0 & ~dac_hi)
			dac_lo_ff <= io_i.wdata;
	end

	always_ff @(posedge clk_i)
	begin
		if (card_clr)
			dac_data_ff <= acsc_pkg::DATA_RST;
		else if (word_ev)
			dac_data_ff <= {io_i.wdata[3:0], dac_lo_ff};
	end

	always_ff @(posedge clk_i)
	begin
		if (card_clr)
			dac_chan_ff <= 2'h0;
		else if (hit(io_i.wr, io_i.addr, acsc_pkg::OFS_DAC_CTRL))
			dac_chan_ff <= io_i.wdata[acsc_pkg::DAC_CHAN_LSB +: 2];
		else if (upd_ev & dac_ctrl_ff[acsc_pkg::DAC_AUTO_BIT])
			dac_chan_ff <= dac_chan_ff + 2'h1;
	end

	// Masked channels still see the data; only their strobe and interrupt are withheld
	always_ff @(posedge clk_i)
	begin
		if (dac_clr)
			dac_wr_ff <= 4'h0;
		else if (upd_ev)
			dac_wr_ff <= (4'h1 << dac_chan_ff) & ~mask_ff;
		else
			dac_wr_ff <= 4'h0;
	end

	always_ff @(posedge clk_i)
	begin
		if (dac_clr)
			dac_irq_ff <= 1'b0;
		else
			dac_irq_ff <= upd_ev & ~mask_ff[dac_chan_ff];
	end

	// DAC DMA: start port arms, terminal count ends unless continuing
	always_ff @(posedge clk_i)
	begin
		if (dac_clr)
			dac_act_ff <= 1'b0;
		else if (hit(io_i.wr, io_i.addr, acsc_pkg::OFS_DAC_DMA)
			& dac_ctrl_ff[acsc_pkg::DAC_DMA_BIT])
			dac_act_ff <= 1'b1;
		else if (dma_tc_i & ~dac_ctrl_ff[acsc_pkg::DAC_CONT_BIT])
			dac_act_ff <= 1'b0;
	end

	always_ff @(posedge clk_i)
	begin
		if (dac_clr)
			dac_req_ff <= 1'b0;
		else if (~dac_act_ff)
			dac_req_ff <= hit(io_i.wr, io_i.addr, acsc_pkg::OFS_DAC_DMA)
				& dac_ctrl_ff[acsc_pkg::DAC_DMA_BIT];
		else if (dma_tc_i & ~dac_ctrl_ff[acsc_pkg::DAC_CONT_BIT])
			dac_req_ff <= 1'b0;
		else if (dac_ctrl_ff[acsc_pkg::DAC_TUPD_BIT] ? upd_ev : word_ev)
			dac_req_ff <= 1'b1;
		else if (word_ev)
			dac_req_ff <= 1'b0;
	end

	// Read data: status, ADC bytes; other offsets read zero
	always_ff @(posedge clk_i)
	begin
		if (rst_i)
			rdata_ff <= acsc_pkg::RD_NONE;
		else if (io_i.rd)
		begin
			case (io_i.addr)
				acsc_pkg::OFS_ADC_DATA:
					rdata_ff <= adc_hi ? {4'h0, adc_res_ff[11:8]}
						: adc_res_ff[7:0];
				acsc_pkg::OFS_MUX_STAT:
					rdata_ff <= {dac_chan_ff, adc_chan_ff, pin_q[2],
						st_ff == acsc_pkg::S_CONV};
				default:
					rdata_ff <= acsc_pkg::RD_NONE;
			endcase
		end
	end

	assign io_rdata_o     = rdata_ff;
	assign adc_cfg_o.gain = adc_ctrl_ff[acsc_pkg::ADC_GAIN_LSB +: 2];
	assign adc_cfg_o.diff = adc_ctrl_ff[acsc_pkg::ADC_DIFF_BIT];
	assign adc_cfg_o.chan = adc_chan_ff;
	assign adc_start_o    = adc_start_ff;
	assign adc_tmr_en_o   = adc_ctrl_ff[acsc_pkg::ADC_TMR_BIT];
	assign adc_dma_req_o  = adc_dma_ff;
	assign adc_irq_o      = adc_irq_ff;
	assign dac_data_o     = dac_data_ff;
	assign dac_wr_o       = dac_wr_ff;
	assign dac_chan_o     = dac_chan_ff;
	assign dac_ref_en_o   = dac_ctrl_ff[acsc_pkg::DAC_REF_BIT];
	assign dac_tmr_en_o   = dac_ctrl_ff[acsc_pkg::DAC_TMR_BIT];
	assign dac_dma_req_o  = dac_req_ff;
	assign dac_irq_o      = dac_irq_ff;

	default clocking cb @(posedge clk_i); endclocking
	default disable iff (rst_i);

	property p_io_start;
		start_go && mode == acsc_pkg::MODE_IO |=> adc_start_o
			&& st_ff == acsc_pkg::S_CONV;
	endproperty
	a_io_start: assert property (p_io_start) else $error("io start lost");

	property p_illegal;
		mode == acsc_pkg::MODE_ILLEGAL && !adc_clr |=> !adc_start_o;
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal start");

	property p_busy;
		eoc_done && !adc_clr |=> st_ff == acsc_pkg::S_DONE && adc_irq_o;
	endproperty
	a_busy: assert property (p_busy) else $error("busy not cleared");

	property p_ctrl_keep;
		hit(io_i.rd, io_i.addr, acsc_pkg::OFS_ADC_CTRL) |=>
			$stable(adc_ctrl_ff) && st_ff == acsc_pkg::S_IDLE;
	endproperty
	a_ctrl_keep: assert property (p_ctrl_keep) else $error("adc ctl");

	property p_dac_keep;
		hit(io_i.rd, io_i.addr, acsc_pkg::OFS_DAC_CTRL) |=>
			$stable(dac_ctrl_ff) && !dac_dma_req_o;
	endproperty
	a_dac_keep: assert property (p_dac_keep) else $error("dac ctl");

	property p_master;
		hit(io_i.rd, io_i.addr, acsc_pkg::OFS_DAC_DATA) |=>
			adc_ctrl_ff == 8'h00 && dac_ctrl_ff == 8'h00 && mask_ff == 4'h0;
	endproperty
	a_master: assert property (p_master) else $error("clear failed");

	property p_mask;
		|dac_wr_o |-> (dac_wr_o & $past(mask_ff)) == 4'h0;
	endproperty
	a_mask: assert property (p_mask) else $error("masked write");

	property p_dac_word;
		word_ev && !dac_clr |=> dac_data_o[11:8] == $past(io_i.wdata[3:0])
			&& dac_data_o[7:0] == $past(dac_lo_ff);
	endproperty
	a_dac_word: assert property (p_dac_word) else $error("dac pair");

	property p_auto;
		mode == acsc_pkg::MODE_AUTO && st_ff == acsc_pkg::S_DONE
			&& data_read && !adc_clr |=> adc_start_o;
	endproperty
	a_auto: assert property (p_auto) else $error("no retrigger");

	property p_adc_dma;
		adc_irq_o && adc_ctrl_ff[acsc_pkg::ADC_DMA_BIT]
			&& $stable(adc_ctrl_ff) |-> adc_dma_req_o;
	endproperty
	a_adc_dma: assert property (p_adc_dma) else $error("no dma req");

	c_auto:  cover property (mode == acsc_pkg::MODE_AUTO && data_read
		##1 adc_start_o);
	c_timer: cover property (mode == acsc_pkg::MODE_TIMER ##0 adc_start_o);
	c_dac:   cover property (word_ev ##1 |dac_wr_o);
	c_clear: cover property (hit(io_i.rd, io_i.addr, acsc_pkg::OFS_DAC_DATA));
endmodule

// file: test/acsc_conv_model.sv
/*
 Converter chip model: answers each start pulse with an end-of-conversion
 and a result word. Assumes starts are one-cycle pulses on clk_i.
*/
`timescale 1ns/10ps
module acsc_conv_model (
	input  wire logic        clk_i,
	input  wire logic        start_i,
	input  wire logic [11:0] res_i,
	output logic             eoc_o,
	output logic [11:0]      result_o
);
	int cnt = 0;

	always @(posedge clk_i)
	begin
		if (start_i === 1'b1)
			cnt <= 1;
		else if (cnt != 0)
			cnt <= (cnt == 14) ? 0 : cnt + 1;
	end
	// Result settles before eoc and outlives it by several cycles
	assign eoc_o    = (cnt >= 6) && (cnt <= 11);
	// Outside its valid span the bus shows the inverse, never a held value
	assign result_o = (cnt >= 3) ? res_i : ~res_i;
endmodule

// file: test/adc_dac_sequencing_control_test.sv
/*
 Self-checking bench of the converter sequencing control.
 Assumes the converter model on the ADC side; the bench acts as host.
*/
`timescale 1ns/10ps
module adc_dac_sequencing_control_test;
	logic                   clk_i = 1'b0;
	logic                   rst_i = 1'b1;
	acsc_pkg::acsc_io_req_s io_i  = '0;
	logic [7:0]             io_rdata_o;
	logic                   dma_tc_i = 1'b0;
	logic                   adc_eoc_i;
	logic [11:0]            adc_result_i;
	logic [11:0]            res = 12'hA5C;
	logic                   adc_tick_i = 1'b0;
	logic                   adc_gate_i = 1'b1;
	logic                   dac_tick_i = 1'b0;
	logic                   dac_gate_i = 1'b1;
	acsc_pkg::acsc_adc_cfg_s adc_cfg_o;
	logic                   adc_start_o;
	logic                   adc_tmr_en_o;
	logic                   adc_dma_req_o;
	logic                   adc_irq_o;
	logic [11:0]            dac_data_o;
	logic [3:0]             dac_wr_o;
	logic [3:0]             wr_seen = 4'h0;
	logic [1:0]             dac_chan_o;
	logic                   dac_ref_en_o;
	logic                   dac_tmr_en_o;
	logic                   dac_dma_req_o;
	logic                   dac_irq_o;
	logic [7:0]             d;
	int                     ev [4] = '{0, 0, 0, 0};
	int                     error_cnt = 0;
	int                     checked = 0;
	int                     cycles = 0;

	acsc_top i_dut (.clk_i(clk_i), .rst_i(rst_i), .io_i(io_i),
		.io_rdata_o(io_rdata_o), .dma_tc_i(dma_tc_i),
		.adc_eoc_i(adc_eoc_i), .adc_result_i(adc_result_i),
		.adc_tick_i(adc_tick_i), .adc_gate_i(adc_gate_i),
		.dac_tick_i(dac_tick_i), .dac_gate_i(dac_gate_i),
		.adc_cfg_o(adc_cfg_o), .adc_start_o(adc_start_o),
		.adc_tmr_en_o(adc_tmr_en_o), .adc_dma_req_o(adc_dma_req_o),
		.adc_irq_o(adc_irq_o), .dac_data_o(dac_data_o),
		.dac_wr_o(dac_wr_o), .dac_chan_o(dac_chan_o),
		.dac_ref_en_o(dac_ref_en_o), .dac_tmr_en_o(dac_tmr_en_o),
		.dac_dma_req_o(dac_dma_req_o), .dac_irq_o(dac_irq_o));

	acsc_conv_model i_conv (.clk_i(clk_i), .start_i(adc_start_o),
		.res_i(res), .eoc_o(adc_eoc_i), .result_o(adc_result_i));

	always #5 clk_i = ~clk_i;

	// Pulses last one cycle, so they are counted rather than sampled
	always @(posedge clk_i)
	begin
		cycles++;
		if (adc_start_o === 1'b1) ev[0]++;
		if (adc_irq_o === 1'b1) ev[1]++;
		if (dac_wr_o !== 4'h0)
		begin
			ev[2]++;
			wr_seen = dac_wr_o;
		end
		if (dac_irq_o === 1'b1) ev[3]++;
		if (cycles == 20000)
		begin
			error_cnt++;
			tally_and_finish();
		end
	end

	task automatic tally_and_finish;
		$display("checked %0d error_cnt %0d", checked, error_cnt);
		if (error_cnt == 0 && checked > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	task automatic chk(input logic [15:0] got, input logic [15:0] exp,
		input string what);
		checked++;
		if (got !== exp)
		begin
			error_cnt++;
			$display("MISMATCH t=%0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic wr(input logic [3:0] a, input logic [7:0] v);
		@(negedge clk_i);
		io_i = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: v};
		@(negedge clk_i);
		io_i = '0;
	endtask

	task automatic rd(input logic [3:0] a);
		@(negedge clk_i);
		io_i = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
		@(negedge clk_i);
		io_i = '0;
		d = io_rdata_o;
	endtask

	// Waits a bounded time for event counter k to move
	task automatic wt(input int k, input int lim);
		int base;
		base = ev[k];
		repeat (lim)
		begin
			@(negedge clk_i);
			if (ev[k] != base) return;
		end
		chk(16'h0001, 16'h0000, "event missing");
	endtask

	task automatic quiet(input int k, input int n);
		int base;
		base = ev[k];
		repeat (n) @(negedge clk_i);
		chk(ev[k] - base, 16'h0000, "unexpected event");
	endtask

	task automatic tick(input logic dac);
		@(negedge clk_i);
		{dac_tick_i, adc_tick_i} = dac ? 2'b10 : 2'b01;
		repeat (3) @(negedge clk_i);
		{dac_tick_i, adc_tick_i} = 2'b00;
	endtask

	task automatic mode(input logic [7:0] v);
		wr(4'h4, v);
		repeat (acsc_pkg::MODE_SETTLE_CYC) @(negedge clk_i);
		rd(4'h4);
	endtask

	task automatic t_idle;
		rd(4'h6);
		chk(d, 8'h02, "status after reset");
		rd(4'h9);
		chk(d, 8'h00, "unmapped read");
		adc_gate_i = 1'b0;
		repeat (4) @(negedge clk_i);
		rd(4'h6);
		chk(d, 8'h00, "gate low status");
		adc_gate_i = 1'b1;
		$display("t_idle done");
	endtask

	task automatic t_io;
		wr(4'h6, 8'h50);
		chk(adc_cfg_o.chan, 4'h5, "adc channel");
		wr(4'h5, 8'h00);
		wt(0, 5);
		rd(4'h6);
		chk(d, 8'h17, "busy status");
		wt(1, 30);
		rd(4'h6);
		chk(d, 8'h16, "done status");
		rd(4'h3);
		chk(d, 8'h5C, "low byte");
		rd(4'h3);
		chk(d, 8'h0A, "high byte");
		quiet(0, 10);
		$display("t_io done");
	endtask

	task automatic t_auto;
		mode(8'h60);
		res = 12'h3C7;
		wr(4'h5, 8'h00);
		wt(0, 5);
		wt(1, 30);
		rd(4'h3);
		chk(d, 8'hC7, "auto low byte");
		quiet(0, 8);
		rd(4'h3);
		chk(d, 8'h03, "auto high byte");
		wt(0, 8);
		wt(1, 30);
		chk(adc_cfg_o.chan, 4'h7, "auto channel");
		mode(8'h00);
		$display("t_auto done");
	endtask

	task automatic t_timer;
		mode(8'hD8);
		chk(adc_tmr_en_o, 1'b1, "timer enable");
		wr(4'h5, 8'h00);
		quiet(0, 10);
		tick(1'b0);
		wt(0, 8);
		wt(1, 30);
		@(negedge clk_i);
		chk(adc_dma_req_o, 1'b1, "dma request");
		rd(4'h3);
		rd(4'h3);
		@(negedge clk_i);
		chk(adc_dma_req_o, 1'b0, "dma request cleared");
		adc_gate_i = 1'b0;
		tick(1'b0);
		quiet(0, 12);
		adc_gate_i = 1'b1;
		mode(8'h88);
		wr(4'h5, 8'h00);
		tick(1'b0);
		quiet(0, 20);
		mode(8'h00);
		$display("t_timer done");
	endtask

	task automatic t_gain;
		for (int g = 0; g < 4; g++)
		begin
			wr(4'h4, 8'h04 | g);
			chk(adc_cfg_o.gain, g, "gain");
			chk(adc_cfg_o.diff, 1'b1, "differential");
		end
		wr(4'h4, 8'h00);
		chk(adc_cfg_o.diff, 1'b0, "single ended");
		$display("t_gain done");
	endtask

	task automatic t_dac;
		int b;
		wr(4'h6, 8'h00);
		wr(4'h1, 8'h06);
		chk(dac_chan_o, 2'h2, "dac channel");
		chk(dac_ref_en_o, 1'b1, "reference on");
		b = ev[3];
		wr(4'h0, 8'h34);
		wr(4'h0, 8'h12);
		@(negedge clk_i);
		chk(wr_seen, 4'h4, "channel strobe");
		chk(dac_data_o, 12'h234, "dac data");
		chk(ev[3] - b, 16'h0001, "dac irq");
		wr(4'h6, 8'h04);
		b = ev[2];
		wr(4'h0, 8'h56);
		wr(4'h0, 8'h07);
		repeat (3) @(negedge clk_i);
		chk(ev[2] - b, 16'h0000, "masked strobe");
		wr(4'h6, 8'h00);
		wr(4'h0, 8'h78);
		rd(4'h1);
		chk(dac_ref_en_o, 1'b1, "ctrl kept");
		wr(4'h0, 8'h9A);
		wr(4'h0, 8'h05);
		@(negedge clk_i);
		chk(dac_data_o, 12'h59A, "pointer reset");
		wr(4'h1, 8'h16);
		wr(4'h2, 8'h00);
		@(negedge clk_i);
		chk(dac_dma_req_o, 1'b1, "dac dma start");
		dma_tc_i = 1'b1;
		@(negedge clk_i);
		dma_tc_i = 1'b0;
		@(negedge clk_i);
		chk(dac_dma_req_o, 1'b0, "stop at count");
		$display("t_dac done");
	endtask

	task automatic t_dtick;
		int b;
		wr(4'h6, 8'h00);
		wr(4'h1, 8'hAC);
		tick(1'b1);
		repeat (3) @(negedge clk_i);
		chk(wr_seen, 4'h1, "tick strobe");
		chk(dac_chan_o, 2'h1, "auto increment");
		tick(1'b1);
		repeat (3) @(negedge clk_i);
		chk(wr_seen, 4'h2, "next channel");
		dac_gate_i = 1'b0;
		b = ev[2];
		tick(1'b1);
		repeat (3) @(negedge clk_i);
		chk(ev[2] - b, 16'h0000, "gated tick");
		dac_gate_i = 1'b1;
		$display("t_dtick done");
	endtask

	task automatic t_clear;
		wr(4'h1, 8'h0E);
		chk(dac_tmr_en_o, 1'b1, "dac timer");
		wr(4'h4, 8'h07);
		rd(4'h4);
		chk(adc_cfg_o.gain, 2'h3, "adc ctrl kept");
		rd(4'h0);
		@(negedge clk_i);
		chk(adc_cfg_o, 7'h00, "clear adc");
		chk({dac_ref_en_o, dac_tmr_en_o, dac_chan_o}, 4'h0, "clear dac");
		$display("t_clear done");
	endtask

	initial
	begin
		repeat (2) @(negedge clk_i);
		rst_i = 1'b0;
		// Pin synchronisers restart at zero; let the gate level arrive
		repeat (2) @(negedge clk_i);
		t_idle();
		t_io();
		t_auto();
		t_timer();
		t_gain();
		t_dac();
		t_dtick();
		t_clear();
		tally_and_finish();
	end
endmodule
